// ===== hw/x21m_pkg.sv
// package: constants for the x21 lead monitor and time-out alarm block
package x21m_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int MS_W = 17;

  // A delays, test/status variant, positions 0..7, in ms (0 = none)
  localparam logic [MS_W-1:0] A_TEST_MS [0:7] = '{
    17'h00000, 17'd900, 17'd1900, 17'd3900, 17'd7900, 17'd15900, 17'd31900, 17'd63900};
  // A delays, standard variant, positions 0..f, in ms
  localparam logic [MS_W-1:0] A_STD_MS [0:15] = '{
    17'h00000, 17'd1900, 17'd7900, 17'd9900, 17'd31900, 17'd33900, 17'd39900, 17'd41900,
    17'd63900, 17'd65900, 17'd71900, 17'd73900, 17'd95900, 17'd97900, 17'd103900,
    17'd105900};
  // B delays, positions 0..7, in ms
  localparam logic [MS_W-1:0] B_MS [0:7] = '{
    17'h00000, 17'd55, 17'd117, 17'd242, 17'd492, 17'd992, 17'd1900, 17'd3900};

  // register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] ADDR_EVENT_CLEAR = 8'h0c;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_ALARM_RESET = 8'h14;

  // config fields
  localparam int CFG_A_SEL_LSB = 0;
  localparam int CFG_B_SEL_LSB = 4;
  localparam int CFG_TEST_VARIANT = 7;
  localparam int CFG_MODE_LSB = 8;
  localparam int CFG_B_ENABLE = 10;
  localparam int CFG_GROUP_LSB = 11;
  localparam int CFG_A_ENABLE = 16;
  localparam int CFG_W = 17;
  localparam logic [CFG_W-1:0] CFG_RESET = 17'h10480;

  // status fields
  localparam int ST_LEADS_LSB = 0;
  localparam int ST_ALARM_A = 6;
  localparam int ST_ALARM_B = 7;
  localparam int ST_POS_B = 8;
  localparam int ST_QUIET_LSB = 9;

  // event bits
  localparam int EV_ALARM_A = 0;
  localparam int EV_ALARM_B = 1;
  localparam int EV_SWITCHED_B = 2;
  localparam int EV_W = 3;

  // alarm output modes
  typedef enum logic [1:0] {
    X21M_MODE_BOTH = 2'h0,
    X21M_MODE_OFF = 2'h1,
    X21M_MODE_VISUAL = 2'h2
  } x21m_mode_t;

  // quiescent indicator positions
  localparam int Q_S1 = 0;
  localparam int Q_S14 = 1;
  localparam int Q_S18 = 2;
  localparam int Q_S22 = 3;
  localparam int Q_S23 = 4;
  localparam int Q_S24 = 5;
  localparam logic [5:0] QUIET_RESET = 6'h01;

  localparam int GROUPS = 5;
endpackage

// ===== hw/x21m_delay_if.sv
// interface: delay selector positions to delay lengths in ms
`timescale 1ns/1ns
`default_nettype none
interface x21m_delay_if;
  logic [3:0] a_sel;
  logic [2:0] b_sel;
  logic test_variant;
  logic [x21m_pkg::MS_W-1:0] a_ms;
  logic [x21m_pkg::MS_W-1:0] b_ms;
  modport table_side (input a_sel, input b_sel, input test_variant, output a_ms, output b_ms);
  modport user_side (output a_sel, output b_sel, output test_variant, input a_ms, input b_ms);
endinterface
`default_nettype wire

// ===== hw/x21m_delay_table.sv
// module: registered lookup of the fixed A and B alarm delays
`timescale 1ns/1ns
`default_nettype none
module x21m_delay_table
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // lookup
  x21m_delay_if.table_side dly
);
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      dly.a_ms <= '0;
      dly.b_ms <= '0;
    end
    else
    begin
      // test/status variant has an 8 position A selector, upper bit ignored
      if (dly.test_variant)
        dly.a_ms <= x21m_pkg::A_TEST_MS[dly.a_sel[2:0]];
      else
        dly.a_ms <= x21m_pkg::A_STD_MS[dly.a_sel];
      dly.b_ms <= x21m_pkg::B_MS[dly.b_sel];
    end
  end
endmodule
`default_nettype wire

// ===== hw/x21m_monitor.sv
// module: x21 lead monitor with call time-out alarms, state display and a/b interlock
//
// Function
// - one activity indicator per T, C, R, I, S, B lead, on only while active
// - time C rising to I rising; beyond the A delay raise the A alarm
// - time first to second drop of C and I; beyond B delay raise B alarm
// - A and B alarms have own delay settings and can each be switched off
// - mode selects visual plus audible, nothing, or visual only outputs
// - alarm reset clears alarms; persisting condition times out and alarms again
// - standard variant A delays from 16 position selector, 1.9 to 105.9 s
// - test/status variant A delays from 8 position selector, 0.9 to 63.9 s
// - B delays from 8 position selector, 55 ms to 3.9 s
// - position zero selects no delay; all delays are fixed constants
// - B alarm enable setting gates B alarm, enabled by default
// - test/status variant decodes six quiescent states, one indicator each
// - with no circuit attached the test/status variant lights the state 1 indicator
// - only first module requesting B in a group switches; others stay A
// - groups 1, 2 span chassis; 3, 4 one chassis; V same slot across chassis
// - A/B selection needs local request together with backplane enable
`timescale 1ns/1ns
`default_nettype none
module x21m_monitor
#(
  parameter int TICK_CYCLES = x21m_pkg::TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // monitored leads, 1 = on
  input wire logic lead_t_in,
  input wire logic lead_c_in,
  input wire logic lead_r_in,
  input wire logic lead_i_in,
  input wire logic lead_s_in,
  input wire logic lead_b_in,
  input wire logic circuit_attached_in,
  // front panel
  input wire logic alarm_reset_in,
  input wire logic sw_b_req_in,
  // backplane
  input wire logic bp_enable_in,
  input wire logic [4:0] grp_busy_in,
  output logic [4:0] grp_claim_out,
  // indicators
  output logic [5:0] lead_active_out,
  output logic [5:0] quiet_state_out,
  output logic visual_a_out,
  output logic visual_b_out,
  output logic audible_out,
  output logic pos_b_out,
  output logic irq_out
);
  typedef enum logic [1:0] {
    X21M_SW_A = 2'h1,
    X21M_SW_B = 2'h2
  } x21m_sw_t;

  localparam int NL = 9;

  logic [NL-1:0] raw;
  logic [NL-1:0] sync1_reg;
  logic [NL-1:0] sync2_reg;
  logic [NL-1:0] prev_reg;
  logic [x21m_pkg::CFG_W-1:0] cfg_reg;
  logic [x21m_pkg::EV_W-1:0] ev_reg;
  logic [x21m_pkg::EV_W-1:0] ev_en_reg;
  logic [x21m_pkg::EV_W-1:0] ev_set;
  logic [16:0] pre_reg;
  logic tick;
  logic [x21m_pkg::MS_W-1:0] a_cnt_reg;
  logic [x21m_pkg::MS_W-1:0] b_cnt_reg;
  logic a_run_reg;
  logic b_run_reg;
  logic b_phase_reg;
  logic alarm_a_reg;
  logic alarm_b_reg;
  logic alarm_rst;
  logic a_trip;
  logic b_trip;
  logic t_edge_seen_reg;
  logic t_alt_reg;
  logic [5:0] quiet_next;
  x21m_sw_t sw_reg;
  logic grp_ok;
  logic grp_free;
  logic [4:0] grp_sel;
  x21m_delay_if dly ();

  // two-stage synchroniser, the first stage feeds only the second
  assign raw = {alarm_reset_in, sw_b_req_in, circuit_attached_in, lead_b_in, lead_s_in,
    lead_i_in, lead_r_in, lead_c_in, lead_t_in};

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      // preload the pin levels so a lead already on at release gives no false edge
      sync1_reg <= raw;
      sync2_reg <= raw;
      prev_reg <= raw;
    end
    else
    begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire logic t_on = sync2_reg[0];
  wire logic c_on = sync2_reg[1];
  wire logic r_on = sync2_reg[2];
  wire logic i_on = sync2_reg[3];
  wire logic attached = sync2_reg[6];
  wire logic b_req = sync2_reg[7];
  wire logic c_rise = c_on & ~prev_reg[1];
  wire logic c_fall = ~c_on & prev_reg[1];
  wire logic i_fall = ~i_on & prev_reg[3];
  wire logic b_req_rise = b_req & ~prev_reg[7];
  wire logic btn_rise = sync2_reg[8] & ~prev_reg[8];

  // register port
  wire logic wr_cfg = wr_in && addr_in == x21m_pkg::ADDR_CONFIG;
  wire logic wr_clr = wr_in && addr_in == x21m_pkg::ADDR_EVENT_CLEAR;
  wire logic wr_en = wr_in && addr_in == x21m_pkg::ADDR_EVENT_ENABLE;
  wire logic wr_rst = wr_in && addr_in == x21m_pkg::ADDR_ALARM_RESET && wdata_in[0];

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cfg_reg <= x21m_pkg::CFG_RESET;
    else if (wr_cfg)
      cfg_reg <= wdata_in[x21m_pkg::CFG_W-1:0];
  end

  wire logic [3:0] a_sel = cfg_reg[x21m_pkg::CFG_A_SEL_LSB +: 4];
  wire logic [2:0] b_sel = cfg_reg[x21m_pkg::CFG_B_SEL_LSB +: 3];
  wire logic test_variant = cfg_reg[x21m_pkg::CFG_TEST_VARIANT];
  wire logic [1:0] mode = cfg_reg[x21m_pkg::CFG_MODE_LSB +: 2];
  wire logic b_alarm_enable_setting = cfg_reg[x21m_pkg::CFG_B_ENABLE];
  wire logic a_enable = cfg_reg[x21m_pkg::CFG_A_ENABLE];
  assign grp_sel = cfg_reg[x21m_pkg::CFG_GROUP_LSB +: 5];

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rdata_out <= '0;
    else if (rd_in)
    begin
      case (addr_in)
        x21m_pkg::ADDR_CONFIG:
          rdata_out <= {15'h0000, cfg_reg};
        x21m_pkg::ADDR_STATUS:
          rdata_out <= {17'h00000, quiet_state_out, pos_b_out, alarm_b_reg, alarm_a_reg,
            lead_active_out};
        x21m_pkg::ADDR_EVENT:
          rdata_out <= {29'h00000000, ev_reg};
        x21m_pkg::ADDR_EVENT_ENABLE:
          rdata_out <= {29'h00000000, ev_en_reg};
        default:
          rdata_out <= '0;
      endcase
    end
    else
      rdata_out <= '0;
  end

  // fixed delay constants, looked up one cycle after a selector change
  assign dly.a_sel = a_sel;
  assign dly.b_sel = b_sel;
  assign dly.test_variant = test_variant;

  x21m_delay_table u_table (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .dly(dly)
  );

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pre_reg <= '0;
    else if (pre_reg == 17'(TICK_CYCLES - 1))
      pre_reg <= '0;
    else
      pre_reg <= pre_reg + 17'h00001;
  end
  assign tick = pre_reg == 17'(TICK_CYCLES - 1);

  // activity indicators follow the synchronised leads
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      lead_active_out <= '0;
    else
      lead_active_out <= sync2_reg[5:0];
  end

  assign alarm_rst = wr_rst | btn_rise;

  // A timer: call request, C on while waiting for I on
  // position zero means no delay is timed, so that alarm never trips
  assign a_trip = a_run_reg && a_enable && dly.a_ms != '0 && a_cnt_reg >= dly.a_ms;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      a_run_reg <= 1'b0;
      a_cnt_reg <= '0;
    end
    else if (c_rise || (alarm_rst && c_on && !i_on && !a_run_reg))
    begin
      a_run_reg <= 1'b1;
      a_cnt_reg <= '0;
    end
    else if (!c_on || i_on || a_trip)
      a_run_reg <= 1'b0;
    else if (tick && a_cnt_reg != '1)
      a_cnt_reg <= a_cnt_reg + 17'h00001;
  end

  // B timer: call clear, from the first of C and I dropping to the second
  wire logic b_start = (c_fall && i_on) || (i_fall && c_on);
  assign b_trip = b_run_reg && b_alarm_enable_setting && dly.b_ms != '0
    && b_cnt_reg >= dly.b_ms;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      b_phase_reg <= 1'b0;
      b_run_reg <= 1'b0;
      b_cnt_reg <= '0;
    end
    else if (!c_on && !i_on)
    begin
      b_phase_reg <= 1'b0;
      b_run_reg <= 1'b0;
    end
    else if (c_rise)
    begin
      b_phase_reg <= 1'b0;
      b_run_reg <= 1'b0;
    end
    else if (b_start || (alarm_rst && b_phase_reg && !b_run_reg))
    begin
      b_phase_reg <= 1'b1;
      b_run_reg <= 1'b1;
      b_cnt_reg <= '0;
    end
    else if (b_trip)
      b_run_reg <= 1'b0;
    else if (tick && b_cnt_reg != '1)
      b_cnt_reg <= b_cnt_reg + 17'h00001;
  end

  // alarms latch until reset or until their enable is cleared; a new trip in the reset cycle wins
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      alarm_a_reg <= 1'b0;
      alarm_b_reg <= 1'b0;
    end
    else
    begin
      if (a_trip)
        alarm_a_reg <= 1'b1;
      else if (alarm_rst || !a_enable)
        alarm_a_reg <= 1'b0;
      if (b_trip)
        alarm_b_reg <= 1'b1;
      else if (alarm_rst || !b_alarm_enable_setting)
        alarm_b_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      visual_a_out <= 1'b0;
      visual_b_out <= 1'b0;
      audible_out <= 1'b0;
    end
    else
    begin
      visual_a_out <= alarm_a_reg && mode != x21m_pkg::X21M_MODE_OFF;
      visual_b_out <= alarm_b_reg && mode != x21m_pkg::X21M_MODE_OFF;
      audible_out <= (alarm_a_reg || alarm_b_reg) && mode == x21m_pkg::X21M_MODE_BOTH;
    end
  end

  // T alternating 0/1 marks a controlled not ready DTE; seen per 1 ms window
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      t_edge_seen_reg <= 1'b0;
      t_alt_reg <= 1'b0;
    end
    else if (tick)
    begin
      t_alt_reg <= t_edge_seen_reg;
      // a toggle in the tick cycle itself is kept for the new window
      t_edge_seen_reg <= t_on != prev_reg[0];
    end
    else if (t_on != prev_reg[0])
      t_edge_seen_reg <= 1'b1;
  end

  // quiescent decode with C and I both off
  always_comb
  begin
    quiet_next = '0;
    if (!attached)
      quiet_next[x21m_pkg::Q_S1] = 1'b1;
    else if (!c_on && !i_on)
    begin
      quiet_next[x21m_pkg::Q_S1] = !t_alt_reg && t_on && r_on;
      quiet_next[x21m_pkg::Q_S14] = t_alt_reg && r_on;
      quiet_next[x21m_pkg::Q_S18] = !t_alt_reg && t_on && !r_on;
      quiet_next[x21m_pkg::Q_S22] = !t_alt_reg && !t_on && !r_on;
      quiet_next[x21m_pkg::Q_S23] = t_alt_reg && !r_on;
      quiet_next[x21m_pkg::Q_S24] = !t_alt_reg && !t_on && r_on;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      quiet_state_out <= x21m_pkg::QUIET_RESET;
    else if (test_variant)
      quiet_state_out <= quiet_next;
    else
      quiet_state_out <= '0;
  end

  // interlock: refuse B while the selected group is held by another module
  assign grp_ok = $countones(grp_sel) <= 1;
  assign grp_free = (grp_busy_in & grp_sel) == '0;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      sw_reg <= X21M_SW_A;
    else
    begin
      case (sw_reg)
        X21M_SW_A:
          if (b_req_rise && bp_enable_in && grp_ok && grp_free)
            sw_reg <= X21M_SW_B;
        X21M_SW_B:
          // back in A it stays there until the request is made again
          if (!b_req || !bp_enable_in)
            sw_reg <= X21M_SW_A;
        default:
          sw_reg <= X21M_SW_A;
      endcase
    end
  end

  // claim lines: 1, 2 and V go to the interchassis cable, 3 and 4 stay local
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pos_b_out <= 1'b0;
      grp_claim_out <= '0;
    end
    else
    begin
      pos_b_out <= sw_reg == X21M_SW_B;
      grp_claim_out <= (sw_reg == X21M_SW_B && grp_ok) ? grp_sel : 5'h00;
    end
  end

  // events, sticky; set wins over a clear in the same cycle
  assign ev_set = {sw_reg == X21M_SW_A && b_req_rise && bp_enable_in && grp_ok && grp_free,
    b_trip, a_trip};

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ev_reg <= '0;
      ev_en_reg <= '0;
    end
    else
    begin
      ev_reg <= (ev_reg & ~(wr_clr ? wdata_in[x21m_pkg::EV_W-1:0] : 3'h0)) | ev_set;
      if (wr_en)
        ev_en_reg <= wdata_in[x21m_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_out <= 1'b0;
    else
      irq_out <= (ev_reg & ev_en_reg) != '0;
  end
endmodule
`default_nettype wire

// ===== verification/x21m_monitor_chk.sv
// checker: port-level properties of the x21 lead monitor
`timescale 1ns/1ns
`default_nettype none
module x21m_monitor_chk
#(
  parameter int TICK_CYCLES = 10
)
(
  // clock, reset and read port
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // leads and panel
  input wire logic lead_t_in,
  input wire logic lead_c_in,
  input wire logic lead_r_in,
  input wire logic lead_i_in,
  input wire logic lead_s_in,
  input wire logic lead_b_in,
  input wire logic circuit_attached_in,
  input wire logic alarm_reset_in,
  input wire logic sw_b_req_in,
  input wire logic bp_enable_in,
  input wire logic [4:0] grp_busy_in,
  // indicators
  input wire logic [4:0] grp_claim_out,
  input wire logic [5:0] lead_active_out,
  input wire logic [5:0] quiet_state_out,
  input wire logic visual_a_out,
  input wire logic visual_b_out,
  input wire logic audible_out,
  input wire logic pos_b_out
);
  wire logic [5:0] lv = {lead_b_in, lead_s_in, lead_i_in, lead_r_in, lead_c_in, lead_t_in};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  // six settled cycles cover the two sync flops plus the indicator register
  AST_LEADS: assert property ($stable(lv) [*6] |-> lead_active_out == lv)
    else $error("lead indicator differs from settled lead");
  AST_AUDIBLE: assert property (audible_out |-> visual_a_out || visual_b_out)
    else $error("audible alarm without visual alarm");
  AST_QUIET_ONEHOT: assert property ($onehot0(quiet_state_out))
    else $error("more than one quiescent indicator lit");
  AST_IDLE: assert property (!circuit_attached_in [*6]
    |-> quiet_state_out inside {6'h00, 6'h01})
    else $error("detached circuit shows other than state one");
  AST_NO_REQ: assert property (!sw_b_req_in [*6] |-> !pos_b_out)
    else $error("b position held without panel request");
  AST_NO_BP: assert property (!bp_enable_in [*6] |-> !pos_b_out)
    else $error("b position held without backplane enable");
  AST_CLAIM: assert property (grp_claim_out != 5'h00
    |-> pos_b_out && $onehot(grp_claim_out))
    else $error("group claim without single b position");
  AST_BUSY: assert property ($rose(pos_b_out) |-> (grp_claim_out & grp_busy_in) == 5'h00)
    else $error("switched into a group held elsewhere");
  AST_RST_CLEARS: assert property ($rose(alarm_reset_in)
    |-> ##[1:8] !visual_a_out && !visual_b_out)
    else $error("alarm reset did not clear alarms");
  AST_A_NEEDS_C: assert property (!lead_c_in [*8] |-> !$rose(visual_a_out))
    else $error("a alarm rose with c off");
  AST_RDATA_IDLE: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data outside read answer cycle");
endmodule
`default_nettype wire

// ===== verification/x21m_lead_partner.sv
// partner: behavioural dte and dce driving the six monitored x21 leads
`timescale 1ns/1ns
`default_nettype none
module x21m_lead_partner
(
  // clock and circuit state
  input wire logic clk_in,
  input wire logic attached_in,
  input wire logic dte_rdy_in,
  input wire logic dce_rdy_in,
  // call control, delays in cycles; answer delay 0 means the dce never answers
  input wire logic call_in,
  input wire logic [31:0] i_wait_in,
  input wire logic [31:0] clr_gap_in,
  // leads, 1 = on
  output logic lead_t_out,
  output logic lead_c_out,
  output logic lead_r_out,
  output logic lead_i_out,
  output logic lead_s_out,
  output logic lead_b_out
);
  logic c_reg = 1'b0;
  logic i_reg = 1'b0;
  logic call_reg = 1'b0;
  logic [31:0] cnt_reg = 32'h0;
  // a detached circuit carries no signal at all
  assign lead_t_out = attached_in & dte_rdy_in;
  assign lead_r_out = attached_in & dce_rdy_in;
  assign lead_s_out = attached_in;
  assign lead_b_out = attached_in;
  assign lead_c_out = attached_in & c_reg;
  assign lead_i_out = attached_in & i_reg;
  always @(posedge clk_in)
  begin
    call_reg <= call_in;
    cnt_reg <= (call_in != call_reg) ? 32'h0 : cnt_reg + 32'h1;
    c_reg <= call_in;
    if (call_in && i_wait_in != 32'h0 && cnt_reg == i_wait_in)
      i_reg <= 1'b1;
    if (!call_in && cnt_reg == clr_gap_in)
      i_reg <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== verification/x21m_monitor_test.sv
// testbench: call timing rows, then modes, alarm reset, states, interlock and reset
`timescale 1ns/1ns
`default_nettype none
module x21m_monitor_test;
  localparam int TICK = 10;
  typedef struct {logic [31:0] cfg; int iw; int cg; logic [1:0] ex;} x21m_row_t;
  logic clk_in, srst_in, wr_in, rd_in, attached, dte_rdy, dce_rdy, call;
  logic alarm_reset_in, sw_b_req_in, bp_enable_in, visual_a_out, visual_b_out;
  logic audible_out, pos_b_out, irq_out, lead_t, lead_c, lead_r, lead_i, lead_s, lead_b;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, i_wait, clr_gap;
  logic [4:0] grp_busy_in, grp_claim_out;
  logic [5:0] lead_active_out, quiet_state_out;
  int num_errors, n_tests;
  // 900 ms for A and 55 ms for B at ten cycles a tick, straddled on both sides
  // last row: standard variant, its 1.9 s A delay is not reached where 0.9 s would be
  x21m_row_t rows [6] = '{'{32'h10491, 8900, 500, 2'h0}, '{32'h10491, 9100, 600, 2'h3},
    '{32'h10480, 9100, 600, 2'h0}, '{32'h10091, 9100, 600, 2'h1},
    '{32'h00491, 9100, 600, 2'h2}, '{32'h10411, 9100, 600, 2'h2}};
  // dte ready, dce ready, expected one-hot state
  logic [7:0] qv [4] = '{8'hc1, 8'h84, 8'h60, 8'h08};
  logic [7:0] zr [4] = '{8'h20, 8'h0c, 8'h10, 8'h08};
  x21m_monitor #(.TICK_CYCLES(TICK)) u_x21m_monitor (.clk_in(clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .lead_t_in(lead_t), .lead_c_in(lead_c), .lead_r_in(lead_r), .lead_i_in(lead_i),
    .lead_s_in(lead_s), .lead_b_in(lead_b), .circuit_attached_in(attached),
    .alarm_reset_in(alarm_reset_in), .sw_b_req_in(sw_b_req_in), .bp_enable_in(bp_enable_in),
    .grp_busy_in(grp_busy_in), .grp_claim_out(grp_claim_out), .lead_active_out(lead_active_out),
    .quiet_state_out(quiet_state_out), .visual_a_out(visual_a_out), .visual_b_out(visual_b_out),
    .audible_out(audible_out), .pos_b_out(pos_b_out), .irq_out(irq_out));
  x21m_lead_partner u_partner (.clk_in(clk_in), .attached_in(attached), .dte_rdy_in(dte_rdy),
    .dce_rdy_in(dce_rdy), .call_in(call), .i_wait_in(i_wait), .clr_gap_in(clr_gap),
    .lead_t_out(lead_t), .lead_c_out(lead_c), .lead_r_out(lead_r), .lead_i_out(lead_i),
    .lead_s_out(lead_s), .lead_b_out(lead_b));
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // leaves the caller just after the answer edge, so no drive may follow directly
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (90000) @(posedge clk_in);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    {srst_in, attached, dte_rdy, dce_rdy} = 4'hf;
    {wr_in, rd_in, call, alarm_reset_in, sw_b_req_in, bp_enable_in} = 6'h00;
    {addr_in, wdata_in, i_wait, clr_gap, grp_busy_in} = '0;
    num_errors = 0;
    n_tests = 0;
    waitc(4);
    srst_in <= 1'b0;
    wr(x21m_pkg::ADDR_EVENT_ENABLE, 32'h3);
    foreach (rows[k])
    begin
      wr(x21m_pkg::ADDR_CONFIG, rows[k].cfg);
      i_wait <= rows[k].iw;
      clr_gap <= rows[k].cg;
      call <= 1'b1;
      waitc(rows[k].iw + 20);
      call <= 1'b0;
      #1;
      chk(lead_active_out, 6'h3f);
      waitc(rows[k].cg + 20);
      rd(x21m_pkg::ADDR_STATUS);
      chk(rdata_out[7:6], rows[k].ex);
      chk({visual_b_out, visual_a_out}, rows[k].ex);
      chk({audible_out, irq_out}, {2{|rows[k].ex}});
      rd(x21m_pkg::ADDR_EVENT);
      chk(rdata_out[2:0], {1'b0, rows[k].ex});
      wr(x21m_pkg::ADDR_ALARM_RESET, 32'h1);
      wr(x21m_pkg::ADDR_EVENT_CLEAR, 32'h7);
    end
    chk(quiet_state_out, 6'h00);
    // C held without an answer keeps the A condition alive across the reset
    wr(x21m_pkg::ADDR_CONFIG, 32'h10491);
    wr(x21m_pkg::ADDR_EVENT_ENABLE, 32'h1);
    i_wait <= 32'h0;
    call <= 1'b1;
    waitc(9100);
    wr(x21m_pkg::ADDR_EVENT_ENABLE, 32'h0);
    for (int m = 0; m < 3; m++)
    begin
      wr(x21m_pkg::ADDR_CONFIG, 32'h10491 | (m << 8));
      rd(x21m_pkg::ADDR_EVENT);
      chk({rdata_out[0], irq_out}, 2'h2);
      chk({audible_out, visual_a_out}, {m == 0, m != 1});
    end
    waitc(1);
    alarm_reset_in <= 1'b1;
    waitc(8);
    alarm_reset_in <= 1'b0;
    #1;
    chk(visual_a_out, 1'b0);
    waitc(9100);
    call <= 1'b0;
    #1;
    chk(visual_a_out, 1'b1);
    foreach (qv[j])
    begin
      waitc(1);
      dte_rdy <= qv[j][7];
      dce_rdy <= qv[j][6];
      waitc(40);
      #1;
      chk(quiet_state_out, qv[j][5:0]);
    end
    waitc(1);
    attached <= 1'b0;
    wr(x21m_pkg::ADDR_CONFIG, 32'h10c80);
    sw_b_req_in <= 1'b1;
    grp_busy_in <= 5'h1e;
    waitc(10);
    bp_enable_in <= 1'b1;
    sw_b_req_in <= 1'b0;
    #1;
    chk({pos_b_out, quiet_state_out}, 7'h01);
    waitc(8);
    sw_b_req_in <= 1'b1;
    waitc(10);
    sw_b_req_in <= 1'b0;
    grp_busy_in <= 5'h01;
    #1;
    chk({pos_b_out, grp_claim_out}, 6'h21);
    waitc(8);
    sw_b_req_in <= 1'b1;
    waitc(10);
    sw_b_req_in <= 1'b0;
    srst_in <= 1'b1;
    #1;
    chk({pos_b_out, grp_claim_out}, 6'h00);
    waitc(4);
    srst_in <= 1'b0;
    rd(x21m_pkg::ADDR_CONFIG);
    chk(rdata_out, x21m_pkg::CFG_RESET);
    rd(x21m_pkg::ADDR_STATUS);
    chk(rdata_out, 32'h200);
    foreach (zr[j])
    begin
      rd(zr[j]);
      chk(rdata_out, 32'h0);
    end
    give_verdict();
  end
endmodule
bind x21m_monitor x21m_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_x21m_monitor_chk (
  .clk_in(clk_in), .srst_in(srst_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .lead_t_in(lead_t_in), .lead_c_in(lead_c_in), .lead_r_in(lead_r_in), .lead_i_in(lead_i_in),
  .lead_s_in(lead_s_in), .lead_b_in(lead_b_in), .circuit_attached_in(circuit_attached_in),
  .alarm_reset_in(alarm_reset_in), .sw_b_req_in(sw_b_req_in), .bp_enable_in(bp_enable_in),
  .grp_busy_in(grp_busy_in), .grp_claim_out(grp_claim_out), .lead_active_out(lead_active_out),
  .quiet_state_out(quiet_state_out), .visual_a_out(visual_a_out), .visual_b_out(visual_b_out),
  .audible_out(audible_out), .pos_b_out(pos_b_out));
`default_nettype wire
